// >>> logic/tfr_regs.vh
// Constants for the five-channel temperature result formatter
`ifndef TFR_REGS_VH
`define TFR_REGS_VH
`define TFR_WORD_W      16
`define TFR_CODE_W      13
`define TFR_FRAC_ZERO   3'h0
`define TFR_NUM_CHAN    5
`define TFR_NUM_REMOTE  4
`define TFR_SHORT_WORD  16'h8000
`define TFR_ZERO_WORD   16'h0000
`define TFR_ADDR_BASE   7'h48
`define TFR_PTR_BLOCK   8'h80
`define TFR_PTR_LAST    8'h04
`define TFR_PTR_SINGLE  8'h00
`define TFR_BYTE_BITS   4'h8
`define TFR_BIT_LAST    4'h7
`endif

// >>> logic/tfr_i2c_rd.v
// Two-wire slave that sets a pointer and returns temperature words
`timescale 1ns/1ns
`default_nettype none
`include "tfr_regs.vh"
module tfr_i2c_rd (
    input  wire        clk,      // System clock
    input  wire        rst_n,    // Asynchronous reset, active low
    input  wire        scl_s,    // Filtered bus clock level
    input  wire        sda_s,    // Filtered bus data level
    input  wire [6:0]  dev_addr, // Own bus address
    input  wire [15:0] rd_word,  // Word addressed by ptr
    output reg  [7:0]  ptr,      // Current pointer
    output reg         sda_oe    // High while pulling data low
);
    localparam [6:0] S_IDLE = 7'h01;
    localparam [6:0] S_ADDR = 7'h02;
    localparam [6:0] S_AACK = 7'h04;
    localparam [6:0] S_PTR  = 7'h08;
    localparam [6:0] S_WACK = 7'h10;
    localparam [6:0] S_TX   = 7'h20;
    localparam [6:0] S_RACK = 7'h40;

    reg [6:0]  state;
    reg [7:0]  shreg;
    reg [3:0]  bitcnt;
    reg        rw;
    reg        first;
    reg        low_sel;
    reg        acked;
    reg [15:0] word;
    reg [7:0]  txb;
    reg        scl_d;
    reg        sda_d;
    wire       scl_rise = scl_s & ~scl_d;
    wire       scl_fall = ~scl_s & scl_d;
    wire       start    = scl_s & scl_d & sda_d & ~sda_s;
    wire       stop     = scl_s & scl_d & ~sda_d & sda_s;
    wire       in_block = (ptr >= `TFR_PTR_BLOCK) && (ptr < `TFR_PTR_BLOCK + `TFR_PTR_LAST);

    // Bus protocol engine: bits sampled on rise, driven after fall
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state   <= S_IDLE;
            shreg   <= 8'h00;
            bitcnt  <= 4'h0;
            rw      <= 1'b0;
            first   <= 1'b0;
            low_sel <= 1'b0;
            acked   <= 1'b0;
            word    <= `TFR_ZERO_WORD;
            txb     <= 8'h00;
            ptr     <= `TFR_PTR_SINGLE;
            sda_oe  <= 1'b0;
            scl_d   <= 1'b1;
            sda_d   <= 1'b1;
        end else begin
            scl_d <= scl_s;
            sda_d <= sda_s;
            if (start) begin
                state  <= S_ADDR;
                bitcnt <= 4'h0;
                sda_oe <= 1'b0;
            end else if (stop) begin
                state  <= S_IDLE;
                sda_oe <= 1'b0;
            end else begin
                case (state)
                    S_ADDR, S_PTR: begin
                        if (scl_rise) begin
                            shreg  <= {shreg[6:0], sda_s};
                            bitcnt <= bitcnt + 4'h1;
                        end else if (scl_fall && bitcnt == `TFR_BYTE_BITS) begin
                            if (state == S_PTR) begin
                                sda_oe <= 1'b1;
                                state  <= S_WACK;
                                if (first)
                                    ptr <= shreg;
                            end else if (shreg[7:1] == dev_addr) begin
                                sda_oe <= 1'b1;
                                rw     <= shreg[0];
                                state  <= S_AACK;
                            end else begin
                                state <= S_IDLE;
                            end
                        end
                    end
                    S_AACK: begin
                        if (scl_fall) begin
                            bitcnt <= 4'h0;
                            if (rw) begin
                                // Whole word caught at once so bytes never mix
                                word    <= rd_word;
                                txb     <= {rd_word[14:8], 1'b0};
                                sda_oe  <= ~rd_word[15];
                                low_sel <= 1'b0;
                                state   <= S_TX;
                            end else begin
                                sda_oe <= 1'b0;
                                first  <= 1'b1;
                                state  <= S_PTR;
                            end
                        end
                    end
                    S_WACK: begin
                        if (scl_fall) begin
                            sda_oe <= 1'b0;
                            bitcnt <= 4'h0;
                            first  <= 1'b0;
                            state  <= S_PTR;
                        end
                    end
                    S_TX: begin
                        if (scl_fall) begin
                            if (bitcnt == `TFR_BIT_LAST) begin
                                sda_oe <= 1'b0;
                                state  <= S_RACK;
                            end else begin
                                sda_oe <= ~txb[7];
                                txb    <= {txb[6:0], 1'b0};
                                bitcnt <= bitcnt + 4'h1;
                            end
                        end
                    end
                    S_RACK: begin
                        if (scl_rise) begin
                            acked <= ~sda_s;
                            // Block reads step through the mirrored range
                            if (~sda_s && low_sel && in_block)
                                ptr <= ptr + 8'h01;
                            else if (~sda_s && low_sel && ptr == `TFR_PTR_BLOCK + `TFR_PTR_LAST)
                                ptr <= `TFR_PTR_BLOCK;
                        end else if (scl_fall) begin
                            bitcnt <= 4'h0;
                            if (!acked) begin
                                state <= S_IDLE;
                            end else if (!low_sel) begin
                                txb     <= {word[6:0], 1'b0};
                                sda_oe  <= ~word[7];
                                low_sel <= 1'b1;
                                state   <= S_TX;
                            end else begin
                                word    <= rd_word;
                                txb     <= {rd_word[14:8], 1'b0};
                                sda_oe  <= ~rd_word[15];
                                low_sel <= 1'b0;
                                state   <= S_TX;
                            end
                        end
                    end
                    S_IDLE: begin
                        sda_oe <= 1'b0;
                    end
                    default: begin
                        state  <= S_IDLE;
                        sda_oe <= 1'b0;
                    end
                endcase
            end
        end
    end
endmodule
`default_nettype wire

// >>> logic/tfr_top.v
// Temperature result formatter with bus readout and over-temperature alerts
// Overview of operation
// - Keep a separate result word for the local and four remote channels.
// - Store 13 significant bits left-aligned in 16 bits, low three bits zero.
// - One count is 0.0625 degree, so +0.0625 reads as 00 08.
// - Negative readings are two's complement across the whole word.
// - The word spans minus 256 up to 255.9375 degrees.
// - Upper byte holds the integer part above the 1 degree bit, its lowest bit weighted 2 degrees.
// - Lower byte holds the 1 degree bit and the fractional part of the reading.
// - Answer on one of four bus addresses chosen by the select pin.
// - Two alert outputs compare every channel against its programmed limits.
// - A shorted remote diode reports minus 256 degrees.
// - A diode fault or open seen in a conversion sets that channel's flag.
`timescale 1ns/1ns
`default_nettype none
`include "tfr_regs.vh"
module tfr_top #(
    parameter NCH  = `TFR_NUM_CHAN,   // Channels, local first
    parameter CW   = `TFR_CODE_W,     // Significant bits per result
    parameter WW   = `TFR_WORD_W      // Result word width
) (
    input  wire              clk,                        // 125 MHz system clock
    input  wire              rst_n,                      // Asynchronous reset, active low
    input  wire              conv_valid,                 // One-cycle conversion done
    input  wire [2:0]        conv_chan,                  // 0 local, 1..4 remote
    input  wire [CW-1:0]     conv_code,                  // Signed result, 0.0625 per count
    input  wire              conv_short,                 // Remote diode inputs shorted
    input  wire              conv_open,                  // Remote diode fault or open
    input  wire [NCH*WW-1:0] limit_a,                    // First limit per channel
    input  wire [NCH*WW-1:0] limit_b,                    // Second limit per channel
    input  wire [WW-1:0]     hyst,                       // Hysteresis shared by both alerts
    input  wire [1:0]        addr_sel,                   // Select pin: GND, V+, SDA, SCL
    input  wire              scl_in,                     // Bus clock pin
    input  wire              sda_in,                     // Bus data pin level
    output reg               sda_out,                    // Bus data drive value, always low
    output wire              sda_oe,                     // High while pulling data low
    output reg               overtemp_alert_out,         // First alert, high when over
    output reg               second_overtemp_alert_out,  // Second alert, high when over
    output reg  [`TFR_NUM_REMOTE-1:0] remote_open_fault_flag // Open fault per remote
);
    // Three-stage synchronisers for every pin input
    reg  [2:0] scl_sy;
    reg  [2:0] sda_sy;
    reg  [1:0] as0_sy;
    reg  [1:0] as1_sy;
    reg        as0_s3;
    reg        as1_s3;
    reg        scl_f;
    reg        sda_f;
    reg  [1:0] addr_f;

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            scl_sy <= 3'h7;
            sda_sy <= 3'h7;
            as0_sy <= 2'h0;
            as1_sy <= 2'h0;
            as0_s3 <= 1'b0;
            as1_s3 <= 1'b0;
        end else begin
            scl_sy <= {scl_sy[1:0], scl_in};
            sda_sy <= {sda_sy[1:0], sda_in};
            as0_sy <= {as0_sy[0], addr_sel[0]};
            as1_sy <= {as1_sy[0], addr_sel[1]};
            as0_s3 <= as0_sy[1];
            as1_s3 <= as1_sy[1];
        end
    end

    // Accept a level only once the second and third stages agree
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            scl_f  <= 1'b1;
            sda_f  <= 1'b1;
            addr_f <= 2'h0;
        end else begin
            if (scl_sy[1] == scl_sy[2])
                scl_f <= scl_sy[2];
            if (sda_sy[1] == sda_sy[2])
                sda_f <= sda_sy[2];
            if (as0_sy[1] == as0_s3)
                addr_f[0] <= as0_s3;
            if (as1_sy[1] == as1_s3)
                addr_f[1] <= as1_s3;
        end
    end

    // Data line is only ever pulled low
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n)
            sda_out <= 1'b0;
        else
            sda_out <= 1'b0;
    end

    // Formatted result words, one per channel
    reg  [WW-1:0]   word   [0:NCH-1];
    wire [WW-1:0]   fmt_word;
    wire            remote = (conv_chan != 3'h0);
    wire [NCH-1:0]  over_a;
    wire [NCH-1:0]  over_b;

    // Sign already sits in the top bit, so the full range falls out of the shift
    assign fmt_word = (conv_short && remote) ? `TFR_SHORT_WORD
                    : {conv_code, `TFR_FRAC_ZERO};

    genvar g;
    generate
        for (g = 0; g < NCH; g = g + 1) begin : g_chan
            reg                 hot_a;
            reg                 hot_b;
            wire signed [WW:0]  t    = {word[g][WW-1], word[g]};
            wire signed [WW:0]  la   = {limit_a[g*WW+WW-1], limit_a[g*WW +: WW]};
            wire signed [WW:0]  lb   = {limit_b[g*WW+WW-1], limit_b[g*WW +: WW]};
            wire signed [WW:0]  hy   = {1'b0, hyst};

            // Whole word written in one edge, both bytes together
            always @(posedge clk or negedge rst_n) begin
                if (!rst_n)
                    word[g] <= `TFR_ZERO_WORD;
                else if (conv_valid && conv_chan == g)
                    word[g] <= fmt_word;
            end

            // Per-channel limit compare with shared hysteresis
            always @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    hot_a <= 1'b0;
                    hot_b <= 1'b0;
                end else begin
                    if (t >= la)
                        hot_a <= 1'b1;
                    else if (t < la - hy)
                        hot_a <= 1'b0;
                    if (t >= lb)
                        hot_b <= 1'b1;
                    else if (t < lb - hy)
                        hot_b <= 1'b0;
                end
            end
            assign over_a[g] = hot_a;
            assign over_b[g] = hot_b;
        end
    endgenerate

    // Alert outputs follow any channel above its limit
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            overtemp_alert_out        <= 1'b0;
            second_overtemp_alert_out <= 1'b0;
        end else begin
            overtemp_alert_out        <= |over_a;
            second_overtemp_alert_out <= |over_b;
        end
    end

    // Open fault flag follows the latest conversion of each remote channel
    generate
        for (g = 0; g < `TFR_NUM_REMOTE; g = g + 1) begin : g_fault
            always @(posedge clk or negedge rst_n) begin
                if (!rst_n)
                    remote_open_fault_flag[g] <= 1'b0;
                else if (conv_valid && conv_chan == g + 1)
                    remote_open_fault_flag[g] <= conv_open;
            end
        end
    endgenerate

    // Pointer decode: 00..04 single reads, 80..84 block mirror
    wire [7:0]    ptr;
    wire [6:0]    ptr_low = ptr[6:0];
    wire          ptr_hit = (ptr_low <= `TFR_PTR_LAST) &&
                            (ptr == ptr_low || ptr == (`TFR_PTR_BLOCK | ptr_low));
    reg  [WW-1:0] rd_word;

    always @* begin
        rd_word = `TFR_ZERO_WORD;
        if (ptr_hit)
            rd_word = word[ptr[2:0]];
    end

    // Bus address from the select pin strap
    wire [6:0] dev_addr = `TFR_ADDR_BASE | {5'h00, addr_f};

    tfr_i2c_rd u_bus (
        .clk      (clk),
        .rst_n    (rst_n),
        .scl_s    (scl_f),
        .sda_s    (sda_f),
        .dev_addr (dev_addr),
        .rd_word  (rd_word),
        .ptr      (ptr),
        .sda_oe   (sda_oe)
    );
endmodule
`default_nettype wire

// >>> testbench/tfr_top_assertions.sv
// Port assertions for the temperature result formatter
`timescale 1ns/1ns
`default_nettype none
module tfr_chk #(
    parameter NCH = 5,  // Channels
    parameter CW  = 13, // Code bits
    parameter WW  = 16  // Word bits
) (
    input wire logic              clk,                       // Clock
    input wire logic              rst_n,                     // Reset, active low
    input wire logic              conv_valid,                // Conversion strobe
    input wire logic [2:0]        conv_chan,                 // Channel
    input wire logic [CW-1:0]     conv_code,                 // Code
    input wire logic              conv_short,                // Shorted diode
    input wire logic              conv_open,                 // Open diode
    input wire logic [NCH*WW-1:0] limit_a,                   // First limits
    input wire logic [NCH*WW-1:0] limit_b,                   // Second limits
    input wire logic              sda_out,                   // Data drive value
    input wire logic              overtemp_alert_out,        // First alert
    input wire logic              second_overtemp_alert_out, // Second alert
    input wire logic [3:0]        remote_open_fault_flag     // Fault flags
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    // Stored word of a conversion and whether it meets each limit
    wire [WW-1:0] cw  = (conv_short && conv_chan != 3'h0) ? 16'h8000 : {conv_code, 3'h0};
    wire          ok  = conv_valid && conv_chan < 3'h5;
    wire          rem = ok && conv_chan != 3'h0;
    wire [1:0]    ri  = 2'(conv_chan - 3'h1);
    wire          ha  = ok && $signed(cw) >= $signed(limit_a[conv_chan*WW +: WW]);
    wire          hb  = ok && $signed(cw) >= $signed(limit_b[conv_chan*WW +: WW]);
    a_flag_set: assert property (rem && conv_open |=> remote_open_fault_flag[$past(ri)])
        else $error("fault flag not set");
    a_flag_clear: assert property (rem && !conv_open |=> !remote_open_fault_flag[$past(ri)])
        else $error("fault flag not cleared");
    a_flag_hold: assert property (!rem |=> $stable(remote_open_fault_flag))
        else $error("fault flag moved without remote conversion");
    a_alert_hot: assert property (ha |-> ##3 overtemp_alert_out)
        else $error("first alert missing");
    a_second_hot: assert property (hb |-> ##3 second_overtemp_alert_out)
        else $error("second alert missing");
    a_alert_cause: assert property ($changed(overtemp_alert_out) |-> $past(conv_valid, 3))
        else $error("first alert moved without conversion");
    a_second_cause: assert property ($changed(second_overtemp_alert_out) |-> $past(conv_valid, 3))
        else $error("second alert moved without conversion");
    a_sda_low: assert property (!sda_out)
        else $error("data pin driven high");
    c_fault: cover property (rem && conv_open);
    c_hot: cover property (ha ##3 overtemp_alert_out);
    c_cool: cover property ($fell(overtemp_alert_out));
    c_short: cover property (rem && conv_short);
endmodule
bind tfr_top tfr_chk #(.NCH(NCH), .CW(CW), .WW(WW)) u_chk (
    .clk(clk), .rst_n(rst_n), .conv_valid(conv_valid), .conv_chan(conv_chan),
    .conv_code(conv_code), .conv_short(conv_short), .conv_open(conv_open),
    .limit_a(limit_a), .limit_b(limit_b), .sda_out(sda_out),
    .overtemp_alert_out(overtemp_alert_out),
    .second_overtemp_alert_out(second_overtemp_alert_out),
    .remote_open_fault_flag(remote_open_fault_flag)
);
`default_nettype wire

// >>> testbench/tfr_host.sv
// Two-wire bus host model that reads temperature words
`timescale 1ns/1ns
`default_nettype none
module tfr_host (
    output logic      scl,     // Bus clock, high while idle
    output logic      sda_rel, // High releases data
    input  wire logic sda      // Resolved data wire
);
    int stretch;
    // Idle bus: both lines released
    initial begin
        scl = 1'b1;
        sda_rel = 1'b1;
        stretch = 0;
    end
    // One bit; data moves only while the clock is low
    task automatic bit_x(input logic b, output logic r);
        sda_rel = b;
        #20 scl = 1'b1;
        #20 r = sda;
        #20 scl = 1'b0;
        #(20 + stretch);
    endtask
    // Start or repeated start; waits for the slave to let go first
    task automatic start;
        sda_rel = 1'b1;
        #40 scl = 1'b1;
        #20 sda_rel = 1'b0;
        #20 scl = 1'b0;
        #20;
    endtask
    task automatic stop;
        sda_rel = 1'b0;
        #20 scl = 1'b1;
        #20 sda_rel = 1'b1;
        #40;
    endtask
    // Byte out, most significant bit first, then the slave's answer
    task automatic wbyte(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_x(b[i], r);
        bit_x(1'b1, r);
        ack = !r;
    endtask
    task automatic rbyte(input logic nack, output logic [7:0] b);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_x(1'b1, r);
            b[i] = r;
        end
        bit_x(nack, r);
    endtask
endmodule
`default_nettype wire

// >>> testbench/tb_tfr_top.sv
// Testbench for the temperature result formatter
`timescale 1ns/1ns
`default_nettype none
module tb_tfr_top;
    logic        clk, rst_n, conv_valid, conv_short, conv_open, ack;
    logic [2:0]  conv_chan;
    logic [12:0] conv_code;
    logic [79:0] limit_a, limit_b;
    logic [15:0] hyst, got;
    logic [1:0]  addr_sel;
    logic [15:0] words [5];
    logic [4:0]  hot_a, hot_b;
    logic [3:0]  flags;
    int          err_total, comparisons;
    wire         scl, sda_rel, sda_oe, sda_out, al_a, al_b;
    wire [3:0]   flag;
    wire         sda = sda_rel & ~sda_oe; // Pull-up, any party pulls low
    tfr_top u_dut (.clk(clk), .rst_n(rst_n), .conv_valid(conv_valid), .conv_chan(conv_chan),
        .conv_code(conv_code), .conv_short(conv_short), .conv_open(conv_open),
        .limit_a(limit_a), .limit_b(limit_b), .hyst(hyst), .addr_sel(addr_sel),
        .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
        .overtemp_alert_out(al_a), .second_overtemp_alert_out(al_b),
        .remote_open_fault_flag(flag));
    tfr_host u_host (.scl(scl), .sda_rel(sda_rel), .sda(sda));
    // Clock, 8 ns period
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    task automatic chk(input logic [15:0] g, input logic [15:0] e, input string m);
        comparisons++;
        if (g !== e) begin
            err_total++;
            $display("[ERR] %0t %s got %h exp %h", $time, m, g, e);
        end
    endtask
    task automatic end_sim;
        if (err_total == 0 && comparisons > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // Alert state of one channel with hysteresis
    function automatic logic hot_nx(logic h, logic [15:0] w, logic [15:0] l);
        if ($signed(w) >= $signed(l)) return 1'b1;
        if ($signed({w[15], w}) < $signed({l[15], l}) - $signed({1'b0, hyst})) return 1'b0;
        return h;
    endfunction
    task automatic do_reset;
        rst_n = 1'b0;
        repeat (5) @(posedge clk);
        #1 rst_n = 1'b1;
        words = '{5{16'h0000}};
        hot_a = 5'h00;
        hot_b = 5'h00;
        flags = 4'h0;
        repeat (4) @(posedge clk);
        chk({10'h000, flag, al_a, al_b}, 16'h0000, "reset outputs");
    endtask
    // One conversion pulse, then flag and alert checks once they settle
    task automatic conv(input logic [2:0] c, input logic [12:0] k, input logic s, input logic o);
        logic [15:0] w;
        w = (s && c != 3'h0) ? 16'h8000 : {k, 3'h0};
        @(posedge clk);
        #1 conv_valid = 1'b1;
        conv_chan = c;
        conv_code = k;
        conv_short = s;
        conv_open = o;
        @(posedge clk);
        #1 conv_valid = 1'b0;
        if (c < 3'h5) begin
            words[c] = w;
            hot_a[c] = hot_nx(hot_a[c], w, limit_a[c*16 +: 16]);
            hot_b[c] = hot_nx(hot_b[c], w, limit_b[c*16 +: 16]);
            if (c != 3'h0) flags[c-1] = o;
        end
        repeat (3) @(posedge clk);
        #1;
        chk({12'h000, flag}, {12'h000, flags}, "fault flags");
        chk({14'h0000, al_a, al_b}, {14'h0000, |hot_a, |hot_b}, "alerts");
    endtask
    // Pointer write, repeated start, then n words read high byte first
    task automatic rd(input logic [6:0] a, input logic [7:0] p, input int n,
                      output logic [15:0] g);
        logic [7:0]  hi, lo;
        logic [15:0] e;
        // Start off the clock edge so bus pins never change on a sampling edge
        @(posedge clk);
        #1;
        u_host.start();
        u_host.wbyte({a, 1'b0}, ack);
        chk({15'h0000, ack}, 16'h0001, "address ack");
        u_host.wbyte(p, ack);
        u_host.start();
        u_host.wbyte({a, 1'b1}, ack);
        for (int k = 0; k < n; k++) begin
            e = words[p[7] ? (p[2:0] + k) % 5 : p[2:0]];
            u_host.rbyte(1'b0, hi);
            u_host.rbyte(k == n - 1, lo);
            g = {hi, lo};
            chk({8'h00, hi}, {8'h00, e[15:8]}, "high byte");
            chk({8'h00, lo}, {8'h00, e[7:0]}, "low byte");
        end
        u_host.stop();
    endtask
    // Main sequence
    initial begin
        {conv_valid, conv_chan, conv_code, conv_short, conv_open} = 19'h0_0000;
        addr_sel = 2'h0;
        hyst = 16'h0040;
        for (int c = 0; c < 5; c++) begin
            limit_a[c*16 +: 16] = 16'h1900 + 16'(c * 256);
            limit_b[c*16 +: 16] = 16'h3200 + 16'(c * 256);
        end
        void'($urandom(32'haa17_14bc));
        do_reset();
        rd(7'h48, 8'h80, 5, got);
        conv(3'h1, 13'h1c00, 1'b0, 1'b1);
        conv(3'h2, 13'h0fff, 1'b0, 1'b0);
        conv(3'h3, 13'h0123, 1'b1, 1'b1);
        conv(3'h4, 13'h1000, 1'b0, 1'b0);
        conv(3'h0, 13'h0320, 1'b0, 1'b0);
        conv(3'h0, 13'h0318, 1'b0, 1'b0);
        conv(3'h0, 13'h0317, 1'b0, 1'b0);
        conv(3'h6, 13'h0555, 1'b0, 1'b1);
        conv(3'h0, 13'h0001, 1'b1, 1'b0);
        rd(7'h48, 8'h80, 7, got);
        for (int i = 0; i < 40; i++)
            conv(3'($urandom_range(7)), 13'($urandom), 1'($urandom_range(3) == 0),
                 1'($urandom_range(1)));
        u_host.stretch = 40;
        rd(7'h48, 8'h80, 5, got);
        u_host.stretch = 0;
        rd(7'h48, 8'h02, 2, got);
        for (int a = 0; a < 4; a++) begin
            @(posedge clk);
            #1 addr_sel = 2'(a);
            rd(7'h48 | 7'(a), 8'h03, 1, got);
            u_host.start();
            u_host.wbyte({7'h48 | 7'(a ^ 1), 1'b0}, ack);
            chk({15'h0000, ack}, 16'h0000, "foreign address");
            u_host.stop();
        end
        conv(3'h2, 13'h0246, 1'b0, 1'b0);
        fork
            rd(7'h4b, 8'h02, 1, got);
            begin
                #2800;
                conv(3'h2, 13'h1dbb, 1'b0, 1'b0);
            end
        join
        chk(got, 16'h1230, "word torn by conversion");
        do_reset();
        rd(7'h4b, 8'h80, 5, got);
        end_sim();
    end
    // Watchdog
    initial begin
        #400000;
        err_total++;
        end_sim();
    end
endmodule
`default_nettype wire
